// *** verilog/cbs_defs.svh ***
// Constants for the socket force and control register block.
// Assumes an AXI4-Lite register bus with 32-bit data and byte addresses.
`ifndef CBS_DEFS_SVH
`define CBS_DEFS_SVH
`define CBS_OFF_PRESENT 12'h008
`define CBS_OFF_FORCE 12'h00c
`define CBS_OFF_CONTROL 12'h010
`define CBS_OFF_EVENT 12'h000
`define CBS_OFF_LEVELS 12'h014
`define CBS_FRC_TRIGGER 14
`define CBS_CTL_POLICY 7
`define CBS_CTL_RESET 8'h00
`define CBS_SOCKET_CAPS 4'h3
`define CBS_VCC_OFF 3'h0
`define CBS_VCC_5V 3'h2
`define CBS_VCC_3V 3'h3
`define CBS_VCC_XV 3'h4
`define CBS_VCC_YV 3'h5
`define CBS_VPP_12V 3'h1
`endif

// *** verilog/cbs_pkg.sv ***
// Types for the socket force and control register block.
// Assumes the constants header is included by users of these types.
package cbs_pkg;
  typedef struct packed {
    logic [3:0] caps;
    logic invalid_supply_request_flag;
    logic possible_data_loss_flag;
    logic unrecognized_card_flag;
    logic cardbus_detected_flag;
    logic narrow_card_detected_flag;
  } cbs_present_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic aw_held;
    logic w_held;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic card_clock_stop_policy;
    logic [2:0] card_supply_request;
    logic [2:0] program_supply_request;
    logic ctl_enabled;
    cbs_present_s present;
    logic [3:0] events;
    logic reinterrogate;
    logic clk_stop_allow;
    logic [2:0] vcc_applied;
    logic [2:0] vpp_applied;
  } cbs_state_s;
endpackage

// *** verilog/cbs_socket_regs.sv ***
// Socket force-event and socket control registers behind AXI4-Lite.
// Assumes one clock, synchronous inputs, and card detection done outside.
//
// Register access over AXI4-Lite was left to the implementer.
`include "cbs_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module cbs_socket_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic interrogate_done,
  input wire logic [8:0] interrogate_result,
  input wire logic socket_idle,
  input wire logic host_clock_stopping,
  input wire logic detect2_level,
  input wire logic detect1_level,
  input wire logic status_change_level,
  input wire logic socket_powered_state,
  output logic card_reinterrogate_trigger,
  output logic card_clock_stop_allow,
  output logic [2:0] card_supply_applied,
  output logic [2:0] program_supply_applied,
  output logic [3:0] event_flags,
  output logic [8:0] present_flags
);

  // Refuse address widths outside 6 to 12 bits, at elaboration.
  if (ADDR_W < 6 || ADDR_W > 12) begin : g_bad_addr_w
    $error("cbs_socket_regs: ADDR_W must be 6 to 12");
  end

  cbs_pkg::cbs_state_s st;
  cbs_pkg::cbs_state_s next_st;
  logic [11:0] ar_addr;
  logic [11:0] aw_addr_in;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [3:0] cap_sel;
  logic vcc_ok;
  logic vpp_ok;
  logic req_bad;

  // Zero-extend bus addresses to the internal width.
  assign ar_addr = 12'(s_axi_araddr);
  assign aw_addr_in = 12'(s_axi_awaddr);

  // Expand byte strobes into a bit mask.
  generate
    for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[b*8 +: 8] = {8{st.wstrb[b]}};
    end
  endgenerate

  // Supply legality against card capability and socket capability.
  always_comb begin
    cap_sel = st.present.caps & `CBS_SOCKET_CAPS;
    vcc_ok = 1'b0;
    case (st.card_supply_request)
      `CBS_VCC_OFF: vcc_ok = 1'b1;
      `CBS_VCC_5V: vcc_ok = cap_sel[0];
      `CBS_VCC_3V: vcc_ok = cap_sel[1];
      default: vcc_ok = 1'b0;
    endcase
    vpp_ok = 1'b0;
    case (st.program_supply_request)
      `CBS_VCC_OFF: vpp_ok = 1'b1;
      `CBS_VPP_12V: vpp_ok = (st.card_supply_request != `CBS_VCC_OFF) && vcc_ok;
      `CBS_VCC_5V: vpp_ok = (st.card_supply_request == `CBS_VCC_5V) && vcc_ok;
      `CBS_VCC_3V: vpp_ok = (st.card_supply_request == `CBS_VCC_3V) && vcc_ok;
      default: vpp_ok = 1'b0;
    endcase
    req_bad = !vcc_ok || !vpp_ok || !st.ctl_enabled;
  end

  // Next-state logic for bus handshakes, registers and socket outputs.
  always_comb begin
    next_st = st;
    wval = st.wdata & wmask;
    next_st.reinterrogate = 1'b0;
    // Write address and data are taken in either order.
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = aw_addr_in;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'h0;
      if (st.awaddr[11:2] == `CBS_OFF_FORCE >> 2) begin
        if (st.wstrb[0]) begin
          next_st.events = wval[3:0];
          next_st.present.narrow_card_detected_flag = wval[4];
          next_st.present.cardbus_detected_flag = wval[5];
          next_st.present.unrecognized_card_flag = wval[7];
        end
        if (st.wstrb[1]) begin
          next_st.present.possible_data_loss_flag = wval[8];
          next_st.present.invalid_supply_request_flag = wval[9];
          next_st.present.caps = wval[13:10];
          if (wval[13:10] != 4'h0) begin
            next_st.ctl_enabled = 1'b0;
          end
          if (wval[`CBS_FRC_TRIGGER]) begin
            next_st.reinterrogate = 1'b1;
          end
        end
      end else if (st.awaddr[11:2] == `CBS_OFF_CONTROL >> 2) begin
        if (st.wstrb[0]) begin
          next_st.card_supply_request = wval[6:4];
          next_st.program_supply_request = wval[2:0];
          next_st.card_clock_stop_policy = wval[`CBS_CTL_POLICY];
        end
      end else if (st.awaddr[11:2] != `CBS_OFF_EVENT >> 2 && st.awaddr[11:2] != `CBS_OFF_PRESENT >> 2
                   && st.awaddr[11:2] != `CBS_OFF_LEVELS >> 2) begin
        next_st.bresp = 2'h2;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    // Hardware-set flags win over a forced write in the same cycle.
    if (interrogate_done) begin
      next_st.present.caps = interrogate_result[8:5];
      next_st.present.unrecognized_card_flag = interrogate_result[2];
      next_st.present.cardbus_detected_flag = interrogate_result[1];
      next_st.present.narrow_card_detected_flag = interrogate_result[0];
      next_st.ctl_enabled = 1'b1;
    end
    // The flag is raised once per refused control write, so a later forced clear sticks.
    // invalid request flagged
    if (st.bvalid && st.awaddr[11:2] == `CBS_OFF_CONTROL >> 2 && req_bad
        && !(st.card_supply_request == `CBS_VCC_OFF && st.program_supply_request == `CBS_VCC_OFF)) begin
      next_st.present.invalid_supply_request_flag = 1'b1;
    end
    if (!req_bad) begin
      next_st.vcc_applied = st.card_supply_request;
      next_st.vpp_applied = st.program_supply_request;
    end else if (st.card_supply_request == `CBS_VCC_OFF) begin
      next_st.vcc_applied = `CBS_VCC_OFF;
      next_st.vpp_applied = `CBS_VCC_OFF;
    end
    next_st.clk_stop_allow = socket_idle && (st.card_clock_stop_policy || host_clock_stopping);
    // Read channel: one read at a time.
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'h0;
      next_st.rdata = 32'h0;
      if (ar_addr[11:2] == `CBS_OFF_FORCE >> 2) begin
        next_st.rdata = 32'h0;
      end else if (ar_addr[11:2] == `CBS_OFF_CONTROL >> 2) begin
        next_st.rdata = {24'h0, st.card_clock_stop_policy, st.card_supply_request, 1'b0,
                         st.program_supply_request};
      end else if (ar_addr[11:2] == `CBS_OFF_PRESENT >> 2) begin
        next_st.rdata = {2'h0, `CBS_SOCKET_CAPS == 4'h3, `CBS_SOCKET_CAPS == 4'h3, 14'h0,
                         st.present.caps, st.present.invalid_supply_request_flag,
                         st.present.possible_data_loss_flag, st.present.unrecognized_card_flag, 1'b0,
                         st.present.cardbus_detected_flag, st.present.narrow_card_detected_flag,
                         socket_powered_state, detect2_level, detect1_level, status_change_level};
      end else if (ar_addr[11:2] == `CBS_OFF_EVENT >> 2) begin
        next_st.rdata = {28'h0, st.events};
      end else if (ar_addr[11:2] == `CBS_OFF_LEVELS >> 2) begin
        next_st.rdata = {25'h0, st.ctl_enabled, st.clk_stop_allow, st.vcc_applied[1:0], 1'b0, 2'h0};
      end else begin
        next_st.rresp = 2'h2;
      end
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.ctl_enabled <= 1'b1;
      st.present.caps <= 4'h0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign card_reinterrogate_trigger = st.reinterrogate;
  assign card_clock_stop_allow = st.clk_stop_allow;
  assign card_supply_applied = st.vcc_applied;
  assign program_supply_applied = st.vpp_applied;
  assign event_flags = st.events;
  assign present_flags = st.present;

endmodule
`default_nettype wire

// *** verif/cbs_socket_regs_monitor.sv ***
// Checker for the socket register block, watching top-level ports only.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cbs_socket_regs_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic socket_idle,
  input wire logic host_clock_stopping,
  input wire logic card_reinterrogate_trigger,
  input wire logic card_clock_stop_allow,
  input wire logic [2:0] card_supply_applied
);
  logic [ADDR_W-1:0] rd_addr;
  // Remembers the address of the read in flight.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_force;
    s_axi_rvalid && rd_addr == ADDR_W'(12'h00c);
  endsequence
  a_force_reads_zero: assert property (s_rd_force |-> s_axi_rdata == 32'h0000_0000)
    else $error("force register read not zero");
  a_ctl_high_zero: assert property (s_axi_rvalid && rd_addr == ADDR_W'(12'h010) |->
    s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[3])
    else $error("control register reserved bits not zero");
  a_trigger_pulse: assert property (card_reinterrogate_trigger |=> !card_reinterrogate_trigger)
    else $error("re-interrogation trigger longer than one cycle");
  a_stop_needs_idle: assert property ($past(aresetn) && !$past(socket_idle) |-> !card_clock_stop_allow)
    else $error("clock stop allowed while socket busy");
  a_stop_host_idle: assert property ($past(aresetn) && $past(socket_idle) && $past(host_clock_stopping)
    |-> card_clock_stop_allow)
    else $error("clock stop refused while idle and host stopping");
  a_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_ready_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted before response");
  a_reset_clears: assert property (disable iff (1'b0) !aresetn |=> card_supply_applied == 3'h0)
    else $error("supply not off after reset");
endmodule
`default_nettype wire

// *** verif/cbs_card_model.sv ***
// Behavioural card answering re-interrogation requests from the socket.
// Assumes the trigger is a one-cycle pulse in the register clock domain.
`timescale 1ns/100ps
`default_nettype none
module cbs_card_model #(
  parameter int DELAY = 4,
  parameter logic [8:0] RESULT = 9'h062
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic card_reinterrogate_trigger,
  output logic interrogate_done,
  output logic [8:0] interrogate_result,
  output int trig_count
);
  int cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      trig_count <= 0;
    end else if (card_reinterrogate_trigger) begin
      cnt <= DELAY;
      trig_count <= trig_count + 1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // The result lines carry the answer only while done is high, so stale data is never mistaken for it.
  assign interrogate_done = (cnt == 1);
  assign interrogate_result = interrogate_done ? RESULT : ~RESULT;
endmodule
`default_nettype wire

// *** verif/cbs_socket_regs_tb_top.sv ***
// Self-checking bench for the socket force and control registers.
// Assumes the card model answers a re-interrogation within a few cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module cbs_socket_regs_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic idle = 1'b0, host = 1'b0, done, awready, wready, bvalid, arready, rvalid, trig, allow;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] vcc, vpp, ev;
  logic [2:0] vt [3] = '{3'h1, 3'h3, 3'h2};
  logic [2:0] ve [3] = '{3'h1, 3'h3, 3'h3};
  logic [3:0] evf, lvl = 4'ha, strb = 4'hf;
  logic [8:0] res, pf;
  int mismatches = 0, tests_run = 0, cycles = 0, trig_count;
  // Clock at 100 MHz.
  always #5 aclk = ~aclk;
  cbs_socket_regs cbs_socket_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .interrogate_done(done),
    .interrogate_result(res), .socket_idle(idle), .host_clock_stopping(host), .detect2_level(lvl[2]),
    .detect1_level(lvl[1]), .status_change_level(lvl[0]), .socket_powered_state(lvl[3]),
    .card_reinterrogate_trigger(trig), .card_clock_stop_allow(allow), .card_supply_applied(vcc),
    .program_supply_applied(vpp), .event_flags(evf), .present_flags(pf));
  cbs_card_model cbs_card_model_inst (.aclk(aclk), .aresetn(aresetn), .card_reinterrogate_trigger(trig),
    .interrogate_done(done), .interrogate_result(res), .trig_count(trig_count));
  // Bus write: address and data offered together, each released once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  // Bus read: data and response are taken at the edge where rvalid is high.
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Reads one register and compares it with the expected word.
  task automatic cr(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK("rdata", e, d)
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin mismatches++; end_sim(); end
  end
  // Main sequence of register accesses.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    cr(12'h00c, 32'h0);
    cr(12'h010, 32'h0);
    cr(12'h008, 32'h3000_000a);
    cr(12'h000, 32'h0);
    wr(12'h00c, 32'hffff_bfff, r);
    cr(12'h00c, 32'h0);
    cr(12'h008, 32'h3000_3fba);
    cr(12'h000, 32'h0000_000f);
    wr(12'h010, 32'h0000_0030, r);
    `CHK("vcc", 3'h0, vcc)
    wr(12'h00c, 32'h0, r);
    cr(12'h008, 32'h3000_000a);
    wr(12'h00c, 32'h0000_4000, r);
    while (pf[1] !== 1'b1) @(posedge aclk);
    cr(12'h008, 32'h3000_0c2a);
    `CHK("trig", 1, trig_count)
    ev = 3'h0;
    for (int c = 0; c < 8; c++) begin
      wr(12'h010, {24'hffffff, 1'b0, c[2:0], 4'h8}, r);
      if (c == 0 || c == 2 || c == 3) ev = c[2:0];
      cr(12'h010, {24'h0, 1'b0, c[2:0], 4'h0});
      `CHK("vcc", ev, vcc)
    end
    `CHK("invalid", 1'b1, pf[4])
    for (int i = 0; i < 3; i++) begin
      wr(12'h010, {24'h0, 4'h3, 1'b0, vt[i]}, r);
      cr(12'h010, {24'h0, 4'h3, 1'b0, vt[i]});
      `CHK("vpp", ve[i], vpp)
    end
    for (int i = 0; i < 8; i++) begin
      wr(12'h010, {24'h0, i[2], 7'h33}, r);
      idle <= i[1];
      host <= i[0];
      repeat (2) @(posedge aclk);
      `CHK("allow", i[1] & (i[2] | i[0]), allow)
    end
    // Low byte lane only: events and detect flags change, capability flags stay.
    strb <= 4'h1;
    wr(12'h00c, 32'h0000_3c01, r);
    strb <= 4'hf;
    `CHK("events", 4'h1, evf)
    cr(12'h008, 32'h3000_0e0a);
    cr(12'h014, 32'h0000_0078);
    wr(12'h004, 32'h0000_0001, r);
    `CHK("bresp", 2'h2, r)
    rd(12'h0fc, d, r);
    `CHK("rresp", 2'h2, r)
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    cr(12'h010, 32'h0);
    `CHK("vcc", 3'h0, vcc)
    end_sim();
  end
endmodule
bind cbs_socket_regs cbs_socket_regs_monitor #(.ADDR_W(ADDR_W)) cbs_socket_regs_monitor_inst (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .socket_idle(socket_idle), .host_clock_stopping(host_clock_stopping),
  .card_reinterrogate_trigger(card_reinterrogate_trigger), .card_clock_stop_allow(card_clock_stop_allow),
  .card_supply_applied(card_supply_applied));
`default_nettype wire
